// File: hdl/rtcai_pkg.sv
// Purpose: Shared constants and types for the clock update and alarm interrupt block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Register indexes are kept as printed; byte address is four times the index.
package rtcai_pkg;

    // Register indexes and byte addresses
    localparam logic [3:0]  IDX_MINUTES   = 4'h1;
    localparam logic [3:0]  IDX_HOURS     = 4'h2;
    localparam logic [3:0]  IDX_WEEKDAY   = 4'h3;
    localparam logic [3:0]  IDX_DATE      = 4'h4;
    localparam logic [3:0]  IDX_MIN_ALARM = 4'h8;
    localparam logic [3:0]  IDX_HR_ALARM  = 4'h9;
    localparam logic [3:0]  IDX_WD_ALARM  = 4'hA;
    localparam logic [3:0]  IDX_EXT_CTRL  = 4'hD;
    localparam logic [3:0]  IDX_FLAGS     = 4'hE;
    localparam logic [3:0]  IDX_IRQ_CTRL  = 4'hF;
    localparam int          ADDR_SHIFT    = 2;
    localparam logic [11:0] ADDR_MINUTES   = 12'h0004;
    localparam logic [11:0] ADDR_HOURS     = 12'h0008;
    localparam logic [11:0] ADDR_WEEKDAY   = 12'h000C;
    localparam logic [11:0] ADDR_DATE      = 12'h0010;
    localparam logic [11:0] ADDR_MIN_ALARM = 12'h0020;
    localparam logic [11:0] ADDR_HR_ALARM  = 12'h0024;
    localparam logic [11:0] ADDR_WD_ALARM  = 12'h0028;
    localparam logic [11:0] ADDR_EXT_CTRL  = 12'h0034;
    localparam logic [11:0] ADDR_FLAGS     = 12'h0038;
    localparam logic [11:0] ADDR_IRQ_CTRL  = 12'h003C;

    // Field positions
    localparam int BIT_ALARM_EXCLUDE  = 7;
    localparam int BIT_WD_SELECT      = 6;
    localparam int BIT_UPD_INTERVAL   = 5;
    localparam int BIT_UPD_FLAG       = 5;
    localparam int BIT_ALARM_FLAG     = 3;
    localparam int BIT_UPD_IRQ_EN     = 5;
    localparam int BIT_ALARM_IRQ_EN   = 3;
    localparam int BIT_CTRL_RESET     = 0;

    // Writable bit masks; other bits are write-protected and read as zero
    localparam logic [7:0] MASK_MINUTES  = 8'h7F;
    localparam logic [7:0] MASK_HOURS    = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY  = 8'h7F;
    localparam logic [7:0] MASK_DATE     = 8'h3F;
    localparam logic [7:0] MASK_IRQ_CTRL = 8'hFD;

    // Values after reset
    localparam logic [7:0] RST_MINUTES  = 8'h00;
    localparam logic [7:0] RST_HOURS    = 8'h00;
    localparam logic [7:0] RST_WEEKDAY  = 8'h01;
    localparam logic [7:0] RST_DATE     = 8'h01;
    localparam logic [7:0] RST_ALARM    = 8'h00;
    localparam logic [7:0] RST_EXT_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
    localparam logic [5:0] RST_SECONDS  = 6'h00;

    // Counter limits; minutes, hours and date packed decimal, seconds binary, weekday one-hot
    localparam logic [5:0] SECONDS_LAST = 6'h3B;
    localparam logic [7:0] MINUTES_LAST = 8'h59;
    localparam logic [7:0] HOURS_LAST   = 8'h23;
    localparam logic [7:0] DATE_LAST    = 8'h31;
    localparam logic [7:0] DATE_FIRST   = 8'h01;
    localparam logic [7:0] WEEKDAY_LAST = 8'h40;

    // Timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int UPD_HOLD_MAX_US = 7800;
    // Microseconds to picoseconds in two steps so the product stays inside int range
    localparam int UPD_HOLD_CYC    = ((UPD_HOLD_MAX_US * 1000) / CLK_PERIOD_PS) * 1000;
    localparam int HOLD_CNT_W      = 21;

    typedef enum logic [1:0] {
        UPD_IDLE = 2'b01,
        UPD_HOLD = 2'b10
    } rtcai_upd_state_t;

    typedef struct packed {
        logic upd_irq_en;
        logic alarm_irq_en;
        logic count_reset;
        logic wd_select;
        logic upd_interval;
    } rtcai_ctrl_t;

endpackage : rtcai_pkg

// File: hdl/rtcai_top.sv
// Purpose: Time counters, update and alarm interrupt sources, shared open-drain request.
// Assumes: I_SEC_TICK is a one-cycle pulse once per second, synchronous to I_REF_CLK.
// Notes:   APB answers with no wait state; read data is captured in the setup cycle.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps

// Behaviour
// - Update flag sets on each update event and stays until software writes zero.
// - Clearing the update flag does not release an update request already driving.
// - Writing one to a sticky event flag leaves that flag unchanged.
// - Update event drives the request low only when update enable is one.
// - Clearing update enable cancels an active update request one cycle after the enable bit clears.
// - Update-driven low releases by itself within 7.8 ms of the event.
// - One source disabled never stops another enabled source driving the request.
// - Alarm flag sets when minute, hour and weekday or date settings match time.
// - Alarm fires only when counters advance into a match, never on programming.
// - Alarm flag stays one until software clears it.
// - Enabled alarm holds the request low until flag or enable is cleared.
// - Clearing alarm enable releases the request at once; enable gates a set flag.
// - Clearing the alarm flag releases an alarm-held request immediately.
// - Alarm event with enable zero leaves the request released.
// - While the control reset bit is one no alarm events are raised.
// - Select zero compares weekday bits; select one compares the date.
// - Alarm registers serve as plain storage; software keeps alarm enable zero then.
// - Write-protected bits ignore writes and read as zero.
// - An alarm register with its exclude bit set is left out of the compare.
// - Interval select picks second updates at zero, minute updates at one.
module rtcai_top
    import rtcai_pkg::*;
#(
    parameter int P_UPD_HOLD_CYC = UPD_HOLD_CYC
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_SEC_TICK,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic             O_INT_N_O,
    output logic             O_INT_N_OE
);

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_inc

    logic [5:0]       sec_ff;
    logic [7:0]       min_ff;
    logic [7:0]       hour_ff;
    logic [7:0]       wday_ff;
    logic [7:0]       date_ff;
    logic [7:0]       alarm_ff [3];
    logic [7:0]       ext_ff;
    logic [7:0]       ctrl_ff;
    logic             upd_flag_ff;
    logic             alarm_flag_ff;
    logic             advanced_ff;
    logic [31:0]      prdata_ff;
    rtcai_upd_state_t upd_state_ff;
    rtcai_upd_state_t nxt_upd_state;
    logic [HOLD_CNT_W-1:0] hold_cnt_ff;
    logic [HOLD_CNT_W-1:0] nxt_hold_cnt;

    rtcai_ctrl_t ctrl;
    assign ctrl.upd_irq_en   = ctrl_ff[BIT_UPD_IRQ_EN];
    assign ctrl.alarm_irq_en = ctrl_ff[BIT_ALARM_IRQ_EN];
    assign ctrl.count_reset  = ctrl_ff[BIT_CTRL_RESET];
    assign ctrl.wd_select    = ext_ff[BIT_WD_SELECT];
    assign ctrl.upd_interval = ext_ff[BIT_UPD_INTERVAL];

    // Bus decode
    wire        setup_phase = I_PSEL & ~I_PENABLE;
    wire        access_wr   = I_PSEL & I_PENABLE & I_PWRITE;
    wire [3:0]  reg_idx     = I_PADDR[ADDR_SHIFT +: 4];
    wire        upper_zero  = (I_PADDR[11:6] == 6'h00) && (I_PADDR[1:0] == 2'b00);
    wire        hit_min     = upper_zero && (reg_idx == IDX_MINUTES);
    wire        hit_hour    = upper_zero && (reg_idx == IDX_HOURS);
    wire        hit_wday    = upper_zero && (reg_idx == IDX_WEEKDAY);
    wire        hit_date    = upper_zero && (reg_idx == IDX_DATE);
    wire        hit_amin    = upper_zero && (reg_idx == IDX_MIN_ALARM);
    wire        hit_ahour   = upper_zero && (reg_idx == IDX_HR_ALARM);
    wire        hit_awd     = upper_zero && (reg_idx == IDX_WD_ALARM);
    wire        hit_ext     = upper_zero && (reg_idx == IDX_EXT_CTRL);
    wire        hit_flags   = upper_zero && (reg_idx == IDX_FLAGS);
    wire        hit_ctrl    = upper_zero && (reg_idx == IDX_IRQ_CTRL);
    wire        mapped      = hit_min | hit_hour | hit_wday | hit_date | hit_amin
                            | hit_ahour | hit_awd | hit_ext | hit_flags | hit_ctrl;
    wire [7:0]  wbyte       = I_PWDATA[7:0];

    wire [7:0] flags_rd = {2'b00, upd_flag_ff, 1'b0, alarm_flag_ff, 3'b000};
    wire [7:0] rd_byte  = hit_min   ? min_ff      :
                          hit_hour  ? hour_ff     :
                          hit_wday  ? wday_ff     :
                          hit_date  ? date_ff     :
                          hit_amin  ? alarm_ff[0] :
                          hit_ahour ? alarm_ff[1] :
                          hit_awd   ? alarm_ff[2] :
                          hit_ext   ? ext_ff      :
                          hit_flags ? flags_rd    :
                          hit_ctrl  ? ctrl_ff     : 8'h00;

    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
    assign O_PRDATA  = prdata_ff;

    // Time base
    wire sec_evt   = I_SEC_TICK & ~ctrl.count_reset;
    wire sec_wrap  = sec_evt && (sec_ff == SECONDS_LAST);
    wire min_wrap  = sec_wrap && (min_ff == MINUTES_LAST);
    wire hour_wrap = min_wrap && (hour_ff == HOURS_LAST);
    wire [7:0] nxt_min  = min_wrap ? 8'h00 : bcd_inc(min_ff);
    wire [7:0] nxt_hour = hour_wrap ? 8'h00 : bcd_inc(hour_ff);
    wire [7:0] nxt_wday = (wday_ff == WEEKDAY_LAST) ? RST_WEEKDAY : {wday_ff[6:0], 1'b0};
    wire [7:0] nxt_date = (date_ff == DATE_LAST) ? DATE_FIRST : bcd_inc(date_ff);

    // Update events
    wire upd_evt = ctrl.upd_interval ? sec_wrap : sec_evt;

    // Alarm compare; each register may be excluded
    wire [2:0] field_hit;
    wire [7:0] time_sel [3];
    assign time_sel[0] = min_ff;
    assign time_sel[1] = hour_ff;
    assign time_sel[2] = ctrl.wd_select ? date_ff : wday_ff;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_alarm_cmp
            logic eq;
            if (g == 2) begin : g_day
                // Weekday may name several days at once
                assign eq = ctrl.wd_select ?
                            (alarm_ff[g][5:0] == time_sel[g][5:0]) :
                            ((alarm_ff[g][6:0] & time_sel[g][6:0]) != 7'h00);
            end else begin : g_time
                // Hour alarm bit 6 is free storage and must not take part in the compare
                localparam logic [7:0] CMP_MASK = (g == 0) ? MASK_MINUTES : MASK_HOURS;
                assign eq = (alarm_ff[g][6:0] & CMP_MASK[6:0])
                         == (time_sel[g][6:0] & CMP_MASK[6:0]);
            end
            assign field_hit[g] = alarm_ff[g][BIT_ALARM_EXCLUDE] | eq;
        end
    endgenerate

    // Compare only on the cycle after the minute counter advances
    wire alarm_evt = advanced_ff & (&field_hit) & ~ctrl.count_reset;

    // Sticky flags: a set in the same cycle as a clear write wins
    wire flag_wr      = access_wr & hit_flags;
    wire clr_upd      = flag_wr & ~wbyte[BIT_UPD_FLAG];
    wire clr_alarm    = flag_wr & ~wbyte[BIT_ALARM_FLAG];
    wire nxt_upd_flag   = upd_evt | (upd_flag_ff & ~clr_upd);
    wire nxt_alarm_flag = alarm_evt | (alarm_flag_ff & ~clr_alarm);

    // Update request holder; flag clear does not touch it
    wire upd_start = upd_evt & ctrl.upd_irq_en;
    always_comb begin
        nxt_upd_state = upd_state_ff;
        nxt_hold_cnt  = hold_cnt_ff;
        case (upd_state_ff)
            UPD_IDLE: begin
                if (upd_start) begin
                    nxt_upd_state = UPD_HOLD;
                    nxt_hold_cnt  = HOLD_CNT_W'(P_UPD_HOLD_CYC - 1);
                end
            end
            UPD_HOLD: begin
                if (!ctrl.upd_irq_en) begin
                    nxt_upd_state = UPD_IDLE;
                end else if (upd_start) begin
                    nxt_hold_cnt = HOLD_CNT_W'(P_UPD_HOLD_CYC - 1);
                end else if (hold_cnt_ff == '0) begin
                    nxt_upd_state = UPD_IDLE;
                end else begin
                    nxt_hold_cnt = hold_cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_upd_state = UPD_IDLE;
            end
        endcase
    end

    // Open-drain request; level tied low, enable is an OR of logic on flop outputs only
    wire upd_active   = (upd_state_ff == UPD_HOLD);
    wire alarm_active = alarm_flag_ff & ctrl.alarm_irq_en;
    assign O_INT_N_O  = 1'b0;
    assign O_INT_N_OE = upd_active | alarm_active;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            upd_state_ff <= UPD_IDLE;
            hold_cnt_ff  <= '0;
        end else begin
            upd_state_ff <= nxt_upd_state;
            hold_cnt_ff  <= nxt_hold_cnt;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            upd_flag_ff   <= 1'b0;
            alarm_flag_ff <= 1'b0;
            advanced_ff   <= 1'b0;
            prdata_ff     <= 32'h0000_0000;
        end else begin
            upd_flag_ff   <= nxt_upd_flag;
            alarm_flag_ff <= nxt_alarm_flag;
            advanced_ff   <= sec_wrap;
            if (setup_phase) begin
                prdata_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Configuration and alarm storage
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            alarm_ff[0] <= RST_ALARM;
            alarm_ff[1] <= RST_ALARM;
            alarm_ff[2] <= RST_ALARM;
            ext_ff      <= RST_EXT_CTRL;
            ctrl_ff     <= RST_IRQ_CTRL;
        end else begin
            if (access_wr && hit_amin) begin
                alarm_ff[0] <= wbyte;
            end
            if (access_wr && hit_ahour) begin
                alarm_ff[1] <= wbyte;
            end
            if (access_wr && hit_awd) begin
                alarm_ff[2] <= wbyte;
            end
            if (access_wr && hit_ext) begin
                ext_ff <= wbyte;
            end
            if (access_wr && hit_ctrl) begin
                ctrl_ff <= wbyte & MASK_IRQ_CTRL;
            end
        end
    end

    // Time counters; a software write wins over a tick in the same cycle
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sec_ff  <= RST_SECONDS;
            min_ff  <= RST_MINUTES;
            hour_ff <= RST_HOURS;
            wday_ff <= RST_WEEKDAY;
            date_ff <= RST_DATE;
        end else begin
            if (ctrl.count_reset) begin
                sec_ff <= RST_SECONDS;
            end else if (sec_evt) begin
                sec_ff <= sec_wrap ? RST_SECONDS : sec_ff + 6'h01;
            end
            if (access_wr && hit_min) begin
                min_ff <= wbyte & MASK_MINUTES;
            end else if (sec_wrap) begin
                min_ff <= nxt_min;
            end
            if (access_wr && hit_hour) begin
                hour_ff <= wbyte & MASK_HOURS;
            end else if (min_wrap) begin
                hour_ff <= nxt_hour;
            end
            if (access_wr && hit_wday) begin
                wday_ff <= wbyte & MASK_WEEKDAY;
            end else if (hour_wrap) begin
                wday_ff <= nxt_wday;
            end
            if (access_wr && hit_date) begin
                date_ff <= wbyte & MASK_DATE;
            end else if (hour_wrap) begin
                date_ff <= nxt_date;
            end
        end
    end

endmodule : rtcai_top

// File: verification/rtcai_chk.sv
// Purpose: Port-level checks for the clock update and alarm interrupt block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   The source behind a low request is not visible here, so rises are tied to causes.
`timescale 1ns/10ps
module rtcai_chk
    import rtcai_pkg::*;
#(
    parameter int P_UPD_HOLD_CYC = UPD_HOLD_CYC
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_SEC_TICK,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [31:0] O_PRDATA,
    input  wire logic        O_PREADY,
    input  wire logic        O_PSLVERR,
    input  wire logic        O_INT_N_O,
    input  wire logic        O_INT_N_OE
);
    logic wr_acc;
    assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    sequence s_access;
        I_PSEL && I_PENABLE;
    endsequence
    sequence s_all_off;
        s_access ##0 (I_PWRITE && I_PADDR == ADDR_IRQ_CTRL && !I_PWDATA[5] && !I_PWDATA[3]);
    endsequence

    chk_all_off: assert property (s_all_off |=> ##1 !O_INT_N_OE)
        else $error("request kept after both enables cleared");
    chk_drive_low: assert property (O_INT_N_OE |-> O_INT_N_O == 1'h0)
        else $error("driven pin level not low");
    chk_rise_cause: assert property ($rose(O_INT_N_OE) |-> $past(I_SEC_TICK)
        || $past(I_SEC_TICK, 2) || $past(wr_acc)) else $error("request rose without cause");
    chk_reset_quiet: assert property ($fell(I_RST) |-> !O_INT_N_OE && O_PRDATA == 32'h0000_0000)
        else $error("outputs not quiet after reset");
    chk_prdata_hi: assert property (O_PRDATA[31:8] == 24'h00_0000)
        else $error("upper read data bits set");
    chk_err_unmap: assert property (s_access ##0 (I_PADDR[11:6] != 6'h00
        || I_PADDR[1:0] != 2'h0) |-> O_PSLVERR) else $error("unmapped access not refused");
    chk_err_phase: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
        else $error("error outside access phase");
    chk_err_mapped: assert property (s_access ##0 I_PADDR == ADDR_FLAGS |-> !O_PSLVERR)
        else $error("mapped access refused");
    chk_ready_acc: assert property (s_access |-> O_PREADY)
        else $error("no ready in access phase");
endmodule : rtcai_chk

bind rtcai_top rtcai_chk #(.P_UPD_HOLD_CYC(P_UPD_HOLD_CYC)) u_rtcai_chk (
    .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_SEC_TICK(I_SEC_TICK), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_INT_N_O(O_INT_N_O), .O_INT_N_OE(O_INT_N_OE));

// File: verification/rtcai_host.sv
// Purpose: Host side of the shared interrupt line.
// Assumes: Open-drain line with a board pull-up.
// Notes:   Never shows a stale driven level once the device lets go.
`timescale 1ns/10ps
module rtcai_host (
    input  wire logic i_int_o,
    input  wire logic i_int_oe,
    output wire logic o_int_n
);
    assign o_int_n = i_int_oe ? i_int_o : 1'h1;
endmodule : rtcai_host

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the clock update and alarm interrupt block.
// Assumes: Hold count cut to 20 cycles; the bench makes the seconds tick.
// Notes:   Expected read words pass through a queue to a monitor process.
`timescale 1ns/10ps
module tb_top
    import rtcai_pkg::*;
;
    localparam int HOLD = 20;
    logic        clk = 0, rst = 1, tick = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, int_o, int_oe, int_n;
    logic [32:0] expq[$];
    int          n_fail = 0, num_checks = 0, seed = 89;
    logic [7:0]  d;
    logic [47:0] c;
    logic [11:0] ra [10] = '{ADDR_MINUTES, ADDR_HOURS, ADDR_WEEKDAY, ADDR_DATE, ADDR_MIN_ALARM,
                            ADDR_HR_ALARM, ADDR_WD_ALARM, ADDR_EXT_CTRL, ADDR_FLAGS, ADDR_IRQ_CTRL};
    logic [7:0]  rv [10] = '{RST_MINUTES, RST_HOURS, RST_WEEKDAY, RST_DATE, RST_ALARM, RST_ALARM,
                            RST_ALARM, RST_EXT_CTRL, 8'h00, RST_IRQ_CTRL};
    logic [7:0]  mk [10] = '{MASK_MINUTES, MASK_HOURS, MASK_WEEKDAY, MASK_DATE, 8'hFF, 8'hFF,
                            8'hFF, 8'hFF, 8'h00, MASK_IRQ_CTRL};
    // ext, minute, hour, day settings, control, fires
    // Last case sets the free bit 6 of the hour setting, which must not block a match
    logic [47:0] cs [10] = '{48'h0001_0001_0801, 48'h4001_0002_0801, 48'h4001_0001_0800,
                            48'h0001_0002_0800, 48'h0000_0001_0800, 48'h2080_8080_0801,
                            48'h0080_8080_0900, 48'h0001_0001_0001, 48'h0001_8001_0801,
                            48'h0001_4001_0801};

    always #2 clk = ~clk;

    rtcai_top #(.P_UPD_HOLD_CYC(HOLD)) u_rtcai_top (
        .I_REF_CLK(clk), .I_RST(rst), .I_SEC_TICK(tick), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_INT_N_O(int_o), .O_INT_N_OE(int_oe));
    rtcai_host u_rtcai_host (.i_int_o(int_o), .i_int_oe(int_oe), .o_int_n(int_n));

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic print_verdict;
        if (n_fail == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Reads note the expected word; the monitor compares at the access edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v,
                       input logic err = 1'h0);
        int n;
        if (!w) expq.push_back({err, 24'h00_0000, v});
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, v};
        @(posedge clk);
        pen <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) begin
            n_fail++;
            print_verdict;
        end
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task automatic pin(input logic e);
        repeat (2) @(posedge clk);
        #1 chk("int_n", {32'h0000_0000, e}, {32'h0000_0000, int_n});
    endtask : pin

    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge clk);
            tick <= 1'h1;
            @(posedge clk);
            tick <= 1'h0;
        end
    endtask : ticks

    always @(posedge clk) begin
        if (psel && pen && !pwr && pready) begin
            if (expq.size() == 0) chk("queue", 33'h0_0000_0000, 33'h1_0000_0000);
            else chk("prdata", expq.pop_front(), {pslverr, prdata});
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        foreach (ra[i]) apb(0, ra[i], rv[i]);
        for (int j = 0; j < 2; j++) begin
            foreach (ra[i]) begin
                d = j ? 8'($random(seed)) : 8'hFF;
                apb(1, ra[i], d);
                apb(0, ra[i], d & mk[i]);
                apb(1, ra[i], rv[i]);
            end
        end
        apb(0, 12'h014, 8'h00, 1'h1);
        apb(1, 12'h040, 8'hFF);
        apb(0, 12'h040, 8'h00, 1'h1);
        apb(1, ADDR_IRQ_CTRL, 8'h20);
        ticks(1);
        pin(1'h0);
        apb(1, ADDR_FLAGS, 8'hFF);
        apb(0, ADDR_FLAGS, 8'h20);
        apb(1, ADDR_FLAGS, 8'h00);
        pin(1'h0);
        apb(0, ADDR_FLAGS, 8'h00);
        repeat (HOLD) @(posedge clk);
        pin(1'h1);
        ticks(1);
        apb(1, ADDR_IRQ_CTRL, 8'h00);
        pin(1'h1);
        ticks(1);
        pin(1'h1);
        apb(0, ADDR_FLAGS, 8'h20);
        apb(1, ADDR_DATE, 8'h02);
        foreach (cs[k]) begin
            c = cs[k];
            apb(1, ADDR_IRQ_CTRL, 8'h01);
            apb(1, ADDR_MINUTES, 8'h00);
            apb(1, ADDR_MIN_ALARM, c[39:32]);
            apb(1, ADDR_HR_ALARM, c[31:24]);
            apb(1, ADDR_WD_ALARM, c[23:16]);
            apb(1, ADDR_EXT_CTRL, c[47:40]);
            apb(1, ADDR_FLAGS, 8'h00);
            apb(1, ADDR_IRQ_CTRL, c[15:8]);
            pin(1'h1);
            ticks(59);
            apb(0, ADDR_FLAGS, (c[8] | c[45]) ? 8'h00 : 8'h20);
            ticks(1);
            apb(0, ADDR_FLAGS, {2'h0, !c[8], 1'h0, c[0], 3'h0});
            pin(!(c[0] && c[11]));
        end
        repeat (40) @(posedge clk);
        pin(1'h0);
        apb(1, ADDR_IRQ_CTRL, 8'h20);
        pin(1'h1);
        apb(1, ADDR_IRQ_CTRL, 8'h08);
        pin(1'h0);
        apb(1, ADDR_FLAGS, 8'h20);
        pin(1'h1);
        print_verdict;
    end
endmodule : tb_top
